/* scg_pkg.sv */
package scg_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] SWITCH_CONTROL_UPPER_OFS = 12'h0A4;
   localparam logic [11:0] GPIO_CONTROL_STATUS_OFS = 12'h0A8;
   localparam int PORT_A_LANE_FLIP_POS = 4;
   localparam int PORT_B_LANE_FLIP_POS = 5;
   localparam int PORT_C_LANE_FLIP_POS = 6;
   localparam int NTB_RESET_OUT_SELECT_POS = 8;
   localparam int PIN_FUNCTION_LSB = 0;
   localparam int PIN_FUNCTION_W = 8;
   localparam int RESET_PIN_IDX = 1;
   localparam logic [7:0] PIN_FUNCTION_RST = 8'h00;
   localparam logic NTB_RESET_OUT_SELECT_RST = 1'h0;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // ----------------------------------------
   // Reset indication pulse length
   // ----------------------------------------
   localparam int RESET_IND_NS = 1000;
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [7:0] RESET_IND_CYCLES =
      8'((RESET_IND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      SCG_RUN = 2'b00,
      SCG_HOT = 2'b01,
      SCG_FUND = 2'b10
   } scg_rst_kind_t;
endpackage

/* scg_lane_latch.sv */
`timescale 1ns/1ps
module scg_lane_latch (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_fund_rst,
   input wire logic [2:0] i_strap,
   input wire logic [2:0] i_pend,
   input wire logic [2:0] i_train,
   output logic [2:0] o_active
);
   import scg_pkg::*;
   logic [2:0] active_ff;
   logic [2:0] nxt_active;

   // ----------------------------------------
   // Link-side copy, changes only at training, at i_fund_rst (strap load) or at reset
   // ----------------------------------------
   always_comb begin
      nxt_active = active_ff;
      if (i_fund_rst) begin
         nxt_active = i_strap;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (i_train[i]) begin
               nxt_active[i] = i_pend[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         active_ff <= 3'h0;
      end else begin
         active_ff <= nxt_active;
      end
   end

   assign o_active = active_ff;
endmodule

/* scg_regs.sv */
`timescale 1ns/1ps
// How it works
// - One lane flip bit per port A, B, C
// - Lane flip bits load from strap pins
// - Config writes override straps
// - New flip applied at next link training
// - Select bit steers reset indication in NTB
// - Select 0: external hot or fundamental reset
// - Select 1: internal hot reset only
// - Internal mode: fundamental reset tri-states pin
// - Pin function bit: 1 alternate, 0 GPIO
// - Sticky fields survive hot reset
module scg_regs (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_hot_rst,
   input wire logic [2:0] i_lane_strap,
   input wire logic i_ntb_mode,
   input wire logic i_ext_hot_rst,
   input wire logic i_ext_fund_rst,
   input wire logic i_int_hot_rst,
   input wire logic [2:0] i_link_train,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [3:0] i_cfg_be,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   output logic [2:0] o_lane_flip,
   output logic [7:0] o_pin_function_select,
   output logic o_reset_indication_out_n,
   output logic o_reset_indication_oe
);
   import scg_pkg::*;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [2:0] flip_ff;
   logic [2:0] nxt_flip;
   logic sel_ff;
   logic nxt_sel;
   logic [7:0] func_ff;
   logic [7:0] nxt_func;
   logic fund_seen_ff;
   logic nxt_fund_seen;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [7:0] ind_cnt_ff;
   logic [7:0] nxt_ind_cnt;
   logic ind_n_ff;
   logic nxt_ind_n;
   logic oe_ff;
   logic nxt_oe;
   logic [7:0] func_q_ff;
   logic [7:0] nxt_func_q;
   logic [2:0] active;
   logic wr_sw;
   logic wr_gp;
   logic rd_ok;
   logic ind_event;
   scg_rst_kind_t kind;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   assign wr_sw = i_cfg_wr && hit(i_cfg_addr, SWITCH_CONTROL_UPPER_OFS);
   assign wr_gp = i_cfg_wr && hit(i_cfg_addr, GPIO_CONTROL_STATUS_OFS);
   // Reads during reset get no answer
   assign rd_ok = i_cfg_rd && i_rst_n;
   // Fundamental reset is the synchronous reset; hot reset keeps sticky state
   assign kind = !i_rst_n ? SCG_FUND : (i_hot_rst ? SCG_HOT : SCG_RUN);

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_comb begin
      nxt_flip = flip_ff;
      nxt_sel = sel_ff;
      nxt_func = func_ff;
      unique case (kind)
         SCG_FUND: begin
            nxt_flip = i_lane_strap;
            nxt_sel = NTB_RESET_OUT_SELECT_RST;
            nxt_func = PIN_FUNCTION_RST;
         end
         SCG_HOT: begin
            nxt_flip = i_lane_strap;
            nxt_sel = NTB_RESET_OUT_SELECT_RST;
            nxt_func = func_ff;
         end
         SCG_RUN: begin
            if (wr_sw && i_cfg_be[0]) begin
               nxt_flip = {i_cfg_wdata[PORT_C_LANE_FLIP_POS],
                           i_cfg_wdata[PORT_B_LANE_FLIP_POS],
                           i_cfg_wdata[PORT_A_LANE_FLIP_POS]};
            end
            if (wr_sw && i_cfg_be[1]) begin
               nxt_sel = i_cfg_wdata[NTB_RESET_OUT_SELECT_POS];
            end
            if (wr_gp && i_cfg_be[0]) begin
               nxt_func = i_cfg_wdata[PIN_FUNCTION_LSB +: PIN_FUNCTION_W];
            end
         end
         default: begin
            nxt_flip = flip_ff;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      flip_ff <= nxt_flip;
      sel_ff <= nxt_sel;
      func_ff <= nxt_func;
   end

   // ----------------------------------------
   // Read data, reserved bits zero
   // ----------------------------------------
   always_comb begin
      nxt_rdata = ZERO_WORD;
      nxt_rvalid = rd_ok;
      if (rd_ok && hit(i_cfg_addr, SWITCH_CONTROL_UPPER_OFS)) begin
         nxt_rdata[PORT_A_LANE_FLIP_POS] = flip_ff[0];
         nxt_rdata[PORT_B_LANE_FLIP_POS] = flip_ff[1];
         nxt_rdata[PORT_C_LANE_FLIP_POS] = flip_ff[2];
         nxt_rdata[NTB_RESET_OUT_SELECT_POS] = sel_ff;
      end else if (rd_ok && hit(i_cfg_addr, GPIO_CONTROL_STATUS_OFS)) begin
         nxt_rdata[PIN_FUNCTION_LSB +: PIN_FUNCTION_W] = func_ff;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
   end

   // ----------------------------------------
   // Reset indication output
   // ----------------------------------------
   // Events are short; stretch so the far side sees them
   assign ind_event = sel_ff ? i_int_hot_rst
                             : (i_ext_hot_rst || i_ext_fund_rst);

   always_comb begin
      nxt_ind_cnt = ind_cnt_ff;
      nxt_ind_n = 1'h1;
      nxt_oe = 1'h0;
      nxt_fund_seen = fund_seen_ff;
      if (!i_rst_n) begin
         nxt_ind_cnt = 8'h00;
         nxt_fund_seen = 1'h1;
      end else begin
         if (ind_event && i_ntb_mode) begin
            nxt_ind_cnt = RESET_IND_CYCLES;
         end else if (ind_cnt_ff != 8'h00) begin
            nxt_ind_cnt = ind_cnt_ff - 8'h01;
         end
         // Write to function or select clears the tri-state hold
         if (wr_gp || wr_sw) begin
            nxt_fund_seen = 1'h0;
         end
         // Fundamental reset in internal mode wins over a write
         if (i_ext_fund_rst && sel_ff) begin
            nxt_fund_seen = 1'h1;
         end
         if (i_ntb_mode && func_ff[RESET_PIN_IDX]) begin
            // Internal mode after fundamental reset: GPIO input, not driven
            nxt_oe = !(sel_ff && fund_seen_ff);
            nxt_ind_n = !(ind_cnt_ff != 8'h00);
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      ind_cnt_ff <= nxt_ind_cnt;
      ind_n_ff <= nxt_ind_n;
      oe_ff <= nxt_oe;
      fund_seen_ff <= nxt_fund_seen;
   end

   // ----------------------------------------
   // Output stage for pin function
   // ----------------------------------------
   // Extra stage keeps the pin mux off the write path
   always_comb begin
      nxt_func_q = func_ff;
   end

   always_ff @(posedge i_clk_sys) begin
      func_q_ff <= nxt_func_q;
   end

   // ----------------------------------------
   // Link-side lane order
   // ----------------------------------------
   scg_lane_latch u_lane (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      // Hot reset retrains every port with the strap values
      .i_fund_rst(i_hot_rst),
      .i_strap(i_lane_strap),
      .i_pend(flip_ff),
      .i_train(i_link_train),
      .o_active(active)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_lane_flip = active;
   assign o_cfg_rdata = rdata_ff;
   assign o_cfg_rvalid = rvalid_ff;
   assign o_pin_function_select = func_q_ff;
   assign o_reset_indication_out_n = ind_n_ff;
   assign o_reset_indication_oe = oe_ff;
endmodule

/* scg_regs_monitor.sv */
`timescale 1ns/1ps
module scg_regs_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_hot_rst,
   input wire logic i_ntb_mode,
   input wire logic [2:0] i_link_train,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] o_cfg_rdata,
   input wire logic o_cfg_rvalid,
   input wire logic [2:0] o_lane_flip,
   input wire logic [7:0] o_pin_function_select,
   input wire logic o_reset_indication_out_n,
   input wire logic o_reset_indication_oe
);
   import scg_pkg::*;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   resv_zero_a: assert property (o_cfg_rvalid |-> o_cfg_rdata[31:9] == 23'h0)
      else $error("reserved read bits set");
   unmap_rd_a: assert property (
      i_cfg_rd && i_cfg_addr[11:4] != 8'h0A |=> o_cfg_rdata == ZERO_WORD)
      else $error("unmapped read not zero");
   rst_state_a: assert property (
      $rose(i_rst_n) |-> o_lane_flip == 3'h0 && !o_reset_indication_oe)
      else $error("bad state after reset");
   func_wr_a: assert property (
      i_cfg_wr && i_cfg_addr == GPIO_CONTROL_STATUS_OFS && i_cfg_be[0]
      |-> ##2 o_pin_function_select == $past(i_cfg_wdata[7:0], 2))
      else $error("pin function not written");
   flip_hold_a: assert property (
      $changed(o_lane_flip) |-> $past(|i_link_train || i_hot_rst))
      else $error("lane flip changed without training");
   sticky_fn_a: assert property (
      i_hot_rst && !i_cfg_wr && !$past(i_cfg_wr) |=> $stable(o_pin_function_select))
      else $error("pin function lost on hot reset");
   ind_len_a: assert property (
      $fell(o_reset_indication_out_n) |-> !o_reset_indication_out_n [*8])
      else $error("indication pulse too short");
   ntb_only_a: assert property (!i_ntb_mode [*2] |-> !o_reset_indication_oe)
      else $error("pin driven outside ntb mode");
endmodule
bind scg_regs scg_regs_chk u_chk (.*);

/* scg_tb.sv */
`timescale 1ns/1ps
module tb;
   import scg_pkg::*;
   logic i_clk_sys = 1'h0, i_rst_n = 1'h0, i_hot_rst = 1'h0, i_ntb_mode = 1'h1, i_cfg_wr = 1'h0;
   logic i_ext_hot_rst = 1'h0, i_ext_fund_rst = 1'h0, i_int_hot_rst = 1'h0, i_cfg_rd = 1'h0;
   logic o_cfg_rvalid, o_reset_indication_out_n, o_reset_indication_oe;
   logic [2:0] i_lane_strap = 3'h5, i_link_train = 3'h0, o_lane_flip;
   logic [11:0] i_cfg_addr = 12'h0;
   logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata, d;
   logic [3:0] i_cfg_be = 4'hF;
   logic [7:0] o_pin_function_select;
   int n_errors = 0, n_checks = 0, cnt = 0;
   scg_regs dut (.*);
   initial forever #25 i_clk_sys = ~i_clk_sys;
   // Generous ceiling, run needs about 165 cycles
   always @(posedge i_clk_sys) if (++cnt == 3000) begin
      n_errors++;
      end_of_test;
   end
   // --------
   // Helpers
   // --------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(negedge i_clk_sys);
      {i_cfg_wr, i_cfg_addr, i_cfg_wdata} = {1'h1, a, v};
      @(negedge i_clk_sys);
      i_cfg_wr = 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(negedge i_clk_sys);
      {i_cfg_rd, i_cfg_addr} = {1'h1, a};
      @(negedge i_clk_sys);
      i_cfg_rd = 1'h0;
      d = o_cfg_rdata;
   endtask
   task automatic trn(input logic [2:0] m);
      cyc(1);
      i_link_train = m;
      cyc(1);
      i_link_train = 3'h0;
      cyc(2);
   endtask
   task automatic pls(input logic [2:0] m);
      @(negedge i_clk_sys);
      {i_ext_hot_rst, i_ext_fund_rst, i_int_hot_rst} = m;
      @(negedge i_clk_sys);
      {i_ext_hot_rst, i_ext_fund_rst, i_int_hot_rst} = 3'h0;
      cyc(2);
   endtask
   task end_of_test;
      $display("errors=%0d checks=%0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_lanes;
      chk(o_lane_flip, 3'h0);
      rd(SWITCH_CONTROL_UPPER_OFS);
      chk(d, 32'h50);
      trn(3'h7);
      chk(o_lane_flip, 3'h5);
      wr(SWITCH_CONTROL_UPPER_OFS, 32'hFFFF_FF20);
      rd(SWITCH_CONTROL_UPPER_OFS);
      chk(d, 32'h120);
      chk(o_lane_flip, 3'h5);
      trn(3'h2);
      chk(o_lane_flip, 3'h7);
      trn(3'h7);
      chk(o_lane_flip, 3'h2);
   endtask
   task automatic t_func;
      wr(GPIO_CONTROL_STATUS_OFS, 32'hA6);
      rd(GPIO_CONTROL_STATUS_OFS);
      chk(d, 32'hA6);
      chk(o_pin_function_select, 8'hA6);
      rd(12'h0B0);
      chk(d, 32'h0);
   endtask
   task automatic t_ind;
      pls(3'h4);
      chk(o_reset_indication_out_n, 1'h1);
      pls(3'h1);
      chk(o_reset_indication_out_n, 1'h0);
      chk(o_reset_indication_oe, 1'h1);
      cyc(25);
      chk(o_reset_indication_out_n, 1'h1);
      wr(SWITCH_CONTROL_UPPER_OFS, 32'h0);
      pls(3'h1);
      chk(o_reset_indication_out_n, 1'h1);
      pls(3'h2);
      chk(o_reset_indication_out_n, 1'h0);
      cyc(25);
      pls(3'h4);
      chk(o_reset_indication_out_n, 1'h0);
      cyc(25);
      i_ntb_mode = 1'h0;
      cyc(3);
      chk(o_reset_indication_oe, 1'h0);
      i_ntb_mode = 1'h1;
   endtask
   task automatic t_resets;
      wr(SWITCH_CONTROL_UPPER_OFS, 32'h100);
      i_hot_rst = 1'h1;
      cyc(2);
      i_hot_rst = 1'h0;
      cyc(3);
      rd(GPIO_CONTROL_STATUS_OFS);
      chk(d, 32'hA6);
      rd(SWITCH_CONTROL_UPPER_OFS);
      chk(d, 32'h50);
      chk(o_lane_flip, 3'h5);
      wr(SWITCH_CONTROL_UPPER_OFS, 32'h100);
      chk(o_reset_indication_oe, 1'h1);
      pls(3'h2);
      chk(o_reset_indication_oe, 1'h0);
      chk(o_reset_indication_out_n, 1'h1);
      wr(GPIO_CONTROL_STATUS_OFS, 32'hA6);
      cyc(1);
      chk(o_reset_indication_oe, 1'h1);
      i_rst_n = 1'h0;
      cyc(3);
      i_rst_n = 1'h1;
      cyc(1);
      chk(o_reset_indication_oe, 1'h0);
      rd(GPIO_CONTROL_STATUS_OFS);
      chk(d, 32'h0);
   endtask
   initial begin
      cyc(12);
      i_rst_n = 1'h1;
      cyc(1);
      t_lanes;
      t_func;
      t_ind;
      t_resets;
      end_of_test;
   end
endmodule
